// ### core/hbc_pkg.sv
// constants and types shared by the bridge input control block
package hbc_pkg;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int CLK_PERIOD_NS = 50;
	localparam int DEGLITCH_NS = 1000;
	localparam int DEAD_NS = 500;
	// least times round up to whole clock cycles
	localparam int DEGLITCH_CYC = (DEGLITCH_NS + CLK_PERIOD_NS - 1) /
		CLK_PERIOD_NS;
	localparam int DEAD_CYC = (DEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ****************************************************************
	// register port
	// ****************************************************************
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h1;
	localparam logic [3:0] REG_INT_STATUS = 4'h2;
	localparam logic [3:0] REG_INT_CLEAR = 4'h3;
	localparam logic [3:0] REG_INT_ENABLE = 4'h4;

	// control register fields
	localparam int CTRL_SRC_BIT = 0;
	localparam int CTRL_SCHEME_BIT = 1;
	localparam int CTRL_IN_A_BIT = 2;
	localparam int CTRL_IN_B_BIT = 3;
	localparam logic [7:0] CTRL_MASK = 8'h0f;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// interrupt fields, shared by status, clear and enable
	localparam int INT_W = 4;
	localparam int INT_UVLO_BIT = 0;
	localparam int INT_OCP_BIT = 1;
	localparam int INT_TSD_BIT = 2;
	localparam int INT_OVP_BIT = 3;
	localparam logic [3:0] INT_RESET = 4'h0;

	// input pin order inside the synchroniser vectors
	localparam int PIN_A = 0;
	localparam int PIN_B = 1;
	localparam int PIN_SLEEP = 2;
	localparam int PIN_N = 3;

	// ****************************************************************
	// types
	// ****************************************************************
	typedef enum logic [1:0] {
		DRV_Z = 2'h0,
		DRV_H = 2'h1,
		DRV_L = 2'h2
	} hbc_drive_e;

	typedef enum logic {
		LEG_DRIVE = 1'h0,
		LEG_DEAD = 1'h1
	} hbc_leg_state_e;

endpackage : hbc_pkg

// ### core/hbc_leg_if.sv
// request and drive state between the decoder and one output leg
`timescale 1ns/1ns
interface hbc_leg_if;
	import hbc_pkg::*;
	hbc_drive_e req;
	hbc_drive_e drive;
	logic dead;
	modport leg (input req, output drive, output dead);
	modport ctl (output req, input drive, input dead);
endinterface : hbc_leg_if

// ### core/hbc_leg.sv
// one output leg: follows the requested state, inserts dead time
`timescale 1ns/1ns
module hbc_leg import hbc_pkg::*; #(
	parameter int DEAD_CYC_P = DEAD_CYC
) (
	input logic clk_in,
	input logic sys_rst_in,
	hbc_leg_if.leg leg_io
);

	localparam int CW = $clog2(DEAD_CYC_P + 1);

	typedef struct packed {
		hbc_leg_state_e mode;
		hbc_drive_e drive;
		logic [CW-1:0] cnt;
	} hbc_leg_s;

	hbc_leg_s st;
	hbc_leg_s next_st;

	// true when the leg would swap between high and low drive
	function automatic logic opposite(hbc_drive_e x, hbc_drive_e y);
		return (x == DRV_H && y == DRV_L) || (x == DRV_L && y == DRV_H);
	endfunction : opposite

	// next state: direct moves to and from high-z, dead gap otherwise
	always_comb begin
		next_st = st;
		unique case (st.mode)
			LEG_DRIVE: begin
				if (opposite(st.drive, leg_io.req)) begin
					next_st.mode = LEG_DEAD;
					next_st.drive = DRV_Z;
					next_st.cnt = CW'(DEAD_CYC_P - 1);
				end else begin
					next_st.drive = leg_io.req;
				end
			end
			LEG_DEAD: begin
				if (st.cnt == '0) begin
					next_st.mode = LEG_DRIVE;
					next_st.drive = leg_io.req;
				end else begin
					next_st.cnt = st.cnt - 1'b1;
				end
			end
		endcase
	end

	// state register
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			st <= '{mode: LEG_DRIVE, drive: DRV_Z, cnt: '0};
		end else begin
			st <= next_st;
		end
	end

	assign leg_io.drive = st.drive;
	assign leg_io.dead = (st.mode == LEG_DEAD);

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);

	property p_dead_entry;
		st.mode == LEG_DRIVE && st.drive == DRV_H && leg_io.req == DRV_L
			|=> st.mode == LEG_DEAD && st.drive == DRV_Z;
	endproperty
	a_dead_entry: assert property (p_dead_entry)
		else $error("high to low swap did not enter dead gap");

	property p_dead_hiz;
		st.mode == LEG_DEAD |-> st.drive == DRV_Z;
	endproperty
	a_dead_hiz: assert property (p_dead_hiz)
		else $error("leg driven during dead gap");

	property p_no_swap;
		(st.drive == DRV_H |=> st.drive != DRV_L) and
		(st.drive == DRV_L |=> st.drive != DRV_H);
	endproperty
	a_no_swap: assert property (p_no_swap)
		else $error("leg swapped drive with no dead gap");

	property p_dead_exit;
		st.mode == LEG_DEAD && st.cnt == '0
			|=> st.mode == LEG_DRIVE && st.drive == $past(leg_io.req);
	endproperty
	a_dead_exit: assert property (p_dead_exit)
		else $error("dead gap did not end on count zero");

	c_dead_gap: cover property ($rose(st.mode == LEG_DEAD));

endmodule : hbc_leg

// ### core/hbc_input_ctrl.sv
// bridge input control: pin sync, deglitch, decode, dead time, faults
`timescale 1ns/1ns
module hbc_input_ctrl import hbc_pkg::*; #(
	parameter int DEGLITCH_CYC_P = DEGLITCH_CYC,
	parameter int DEAD_CYC_P = DEAD_CYC
) (
	input logic clk_in,
	input logic sys_rst_in,
	input logic pin_input_a_in,
	input logic pin_input_b_in,
	input logic sleep_n_pin_in,
	input logic uvlo_in,
	input logic ocp_in,
	input logic tsd_in,
	input logic overvoltage_in,
	input logic fault_n_pin_in,
	output logic fault_n_pin_out,
	output logic fault_n_pin_oe_out,
	output logic bridge_out_a_hs_out,
	output logic bridge_out_a_ls_out,
	output logic bridge_out_b_hs_out,
	output logic bridge_out_b_ls_out,
	input logic [ADDR_W-1:0] reg_addr_in,
	input logic [DATA_W-1:0] reg_wdata_in,
	input logic reg_wr_in,
	input logic reg_rd_in,
	output logic [DATA_W-1:0] reg_rdata_out,
	output logic irq_out
);

	localparam int DGW = $clog2(DEGLITCH_CYC_P + 1);

	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		logic [PIN_N-1:0] sync1;
		logic [PIN_N-1:0] sync2;
		logic [PIN_N-1:0] filt;
		logic [PIN_N-1:0][DGW-1:0] dg_cnt;
		logic [DATA_W-1:0] ctrl;
		logic [INT_W-1:0] int_stat;
		logic [INT_W-1:0] int_en;
		logic [INT_W-1:0] ev_prev;
		logic fault_act;
		logic [DATA_W-1:0] rdata;
	} hbc_ctl_s;

	hbc_ctl_s st;
	hbc_ctl_s next_st;

	logic src_sel;
	logic scheme_sel;
	logic sel_a;
	logic sel_b;
	logic awake;
	logic coast;
	logic ovp_brake;
	hbc_drive_e raw_a;
	hbc_drive_e raw_b;
	logic [INT_W-1:0] ev_now;
	logic [INT_W-1:0] int_clr;
	logic [DATA_W-1:0] status_word;

	hbc_leg_if leg_a_io ();
	hbc_leg_if leg_b_io ();

	// ****************************************************************
	// input selection and decode
	// ****************************************************************

	// control bits and the chosen input pair
	assign src_sel = st.ctrl[CTRL_SRC_BIT];
	assign scheme_sel = st.ctrl[CTRL_SCHEME_BIT];
	assign awake = st.filt[PIN_SLEEP];
	// pins when select is 0, register bits when 1
	assign sel_a = src_sel ? st.ctrl[CTRL_IN_A_BIT] : st.filt[PIN_A];
	assign sel_b = src_sel ? st.ctrl[CTRL_IN_B_BIT] : st.filt[PIN_B];

	// truth tables of the two schemes
	always_comb begin
		raw_a = DRV_L;
		raw_b = DRV_L;
		if (!scheme_sel) begin
			// sel_a is enable, sel_b is phase
			if (sel_a) begin
				raw_a = sel_b ? DRV_H : DRV_L;
				raw_b = sel_b ? DRV_L : DRV_H;
			end
		end else begin
			unique case ({sel_a, sel_b})
				2'h0: begin
					raw_a = DRV_Z;
					raw_b = DRV_Z;
				end
				2'h1: begin
					raw_a = DRV_L;
					raw_b = DRV_H;
				end
				2'h2: begin
					raw_a = DRV_H;
					raw_b = DRV_L;
				end
				2'h3: begin
					raw_a = DRV_L;
					raw_b = DRV_L;
				end
			endcase
		end
	end

	// bridge disabled when both legs idle; overvoltage then brakes
	assign coast = (raw_a == DRV_Z) && (raw_b == DRV_Z);
	assign ovp_brake = overvoltage_in && (!awake || coast);

	// final requests: brake beats sleep, sleep beats decode
	always_comb begin
		if (ovp_brake) begin
			leg_a_io.req = DRV_L;
			leg_b_io.req = DRV_L;
		end else if (!awake) begin
			leg_a_io.req = DRV_Z;
			leg_b_io.req = DRV_Z;
		end else begin
			leg_a_io.req = raw_a;
			leg_b_io.req = raw_b;
		end
	end

	// ****************************************************************
	// output legs
	// ****************************************************************
	hbc_leg #(.DEAD_CYC_P(DEAD_CYC_P)) u_leg_a (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.leg_io(leg_a_io.leg)
	);

	hbc_leg #(.DEAD_CYC_P(DEAD_CYC_P)) u_leg_b (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.leg_io(leg_b_io.leg)
	);

	// transistor gates from the registered leg states
	assign bridge_out_a_hs_out = (leg_a_io.drive == DRV_H);
	assign bridge_out_a_ls_out = (leg_a_io.drive == DRV_L);
	assign bridge_out_b_hs_out = (leg_b_io.drive == DRV_H);
	assign bridge_out_b_ls_out = (leg_b_io.drive == DRV_L);

	// ****************************************************************
	// events and register port
	// ****************************************************************
	assign ev_now = {ovp_brake, tsd_in, ocp_in, uvlo_in};
	assign int_clr = (reg_wr_in && reg_addr_in == REG_INT_CLEAR) ?
		reg_wdata_in[INT_W-1:0] : INT_RESET;
	// fault pin, awake, filtered pins, leg b state, leg a state
	assign status_word = {fault_n_pin_in, awake, st.filt[PIN_B],
		st.filt[PIN_A], leg_b_io.drive, leg_a_io.drive};

	// next state of the whole block
	always_comb begin
		next_st = st;
		// two flops per pin; only the second feeds the filter
		next_st.sync1 = {sleep_n_pin_in, pin_input_b_in,
			pin_input_a_in};
		next_st.sync2 = st.sync1;
		// a new level is taken after it holds for the filter time
		for (int i = 0; i < PIN_N; i++) begin
			if (st.sync2[i] == st.filt[i]) begin
				next_st.dg_cnt[i] = '0;
			end else if (st.dg_cnt[i] == DGW'(DEGLITCH_CYC_P - 1)) begin
				next_st.filt[i] = st.sync2[i];
				next_st.dg_cnt[i] = '0;
			end else begin
				next_st.dg_cnt[i] = st.dg_cnt[i] + 1'b1;
			end
		end
		// sticky flags: a new event wins over a clear
		next_st.ev_prev = ev_now;
		next_st.int_stat = (st.int_stat & ~int_clr) | (ev_now & ~st.ev_prev);
		next_st.fault_act = uvlo_in | ocp_in | tsd_in;
		if (reg_wr_in && reg_addr_in == REG_CTRL) begin
			next_st.ctrl = reg_wdata_in & CTRL_MASK;
		end
		if (reg_wr_in && reg_addr_in == REG_INT_ENABLE) begin
			next_st.int_en = reg_wdata_in[INT_W-1:0];
		end
		// read data stand for one cycle only
		next_st.rdata = '0;
		if (reg_rd_in) begin
			unique case (reg_addr_in)
				REG_CTRL: next_st.rdata = st.ctrl;
				REG_STATUS: next_st.rdata = status_word;
				REG_INT_STATUS: next_st.rdata = DATA_W'(st.int_stat);
				REG_INT_ENABLE: next_st.rdata = DATA_W'(st.int_en);
				default: next_st.rdata = '0;
			endcase
		end
	end

	// state register
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			st <= '{sync1: '0, sync2: '0, filt: '0, dg_cnt: '0,
				ctrl: CTRL_RESET, int_stat: INT_RESET, int_en: INT_RESET,
				ev_prev: INT_RESET, fault_act: 1'b0, rdata: '0};
		end else begin
			st <= next_st;
		end
	end

	// outputs
	assign reg_rdata_out = st.rdata;
	assign irq_out = |(st.int_stat & st.int_en);
	assign fault_n_pin_out = 1'b0; // open drain: only ever pulls low
	assign fault_n_pin_oe_out = st.fault_act;

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);

	property p_src_pins;
		!src_sel |-> sel_a == st.filt[PIN_A] && sel_b == st.filt[PIN_B];
	endproperty
	a_src_pins: assert property (p_src_pins)
		else $error("pin source not selected");

	property p_src_regs;
		src_sel |-> sel_a == st.ctrl[CTRL_IN_A_BIT] &&
			sel_b == st.ctrl[CTRL_IN_B_BIT];
	endproperty
	a_src_regs: assert property (p_src_regs)
		else $error("register source not selected");

	property p_pe_fwd;
		awake && !ovp_brake && !scheme_sel && sel_a && sel_b
			|-> leg_a_io.req == DRV_H && leg_b_io.req == DRV_L;
	endproperty
	a_pe_fwd: assert property (p_pe_fwd)
		else $error("phase/enable forward decode wrong");

	property p_pe_rev;
		awake && !ovp_brake && !scheme_sel && sel_a && !sel_b
			|-> leg_a_io.req == DRV_L && leg_b_io.req == DRV_H;
	endproperty
	a_pe_rev: assert property (p_pe_rev)
		else $error("phase/enable reverse decode wrong");

	property p_pe_brake;
		awake && !scheme_sel && !sel_a
			|-> leg_a_io.req == DRV_L && leg_b_io.req == DRV_L;
	endproperty
	a_pe_brake: assert property (p_pe_brake)
		else $error("phase/enable brake decode wrong");

	property p_pwm_table;
		awake && !ovp_brake && scheme_sel |->
			(leg_a_io.req == (sel_a && !sel_b ? DRV_H :
				(sel_a || sel_b) ? DRV_L : DRV_Z)) &&
			(leg_b_io.req == (!sel_a && sel_b ? DRV_H :
				(sel_a || sel_b) ? DRV_L : DRV_Z));
	endproperty
	a_pwm_table: assert property (p_pwm_table)
		else $error("pwm decode wrong");

	property p_sleep;
		!awake && !ovp_brake |=> !bridge_out_a_hs_out &&
			!bridge_out_a_ls_out && !bridge_out_b_hs_out &&
			!bridge_out_b_ls_out;
	endproperty
	a_sleep: assert property (p_sleep)
		else $error("outputs driven while asleep");

	property p_ovp;
		ovp_brake && leg_a_io.drive != DRV_H && leg_b_io.drive != DRV_H &&
			!leg_a_io.dead && !leg_b_io.dead
			|=> bridge_out_a_ls_out && bridge_out_b_ls_out;
	endproperty
	a_ovp: assert property (p_ovp)
		else $error("overvoltage did not brake");

	property p_fault;
		(uvlo_in || ocp_in || tsd_in) |=> fault_n_pin_oe_out ##1
			(fault_n_pin_oe_out == $past(uvlo_in || ocp_in || tsd_in));
	endproperty
	a_fault: assert property (p_fault)
		else $error("fault pin does not follow faults");

	property p_deglitch;
		st.sync2[PIN_A] != st.filt[PIN_A] &&
			st.dg_cnt[PIN_A] != DGW'(DEGLITCH_CYC_P - 1)
			|=> $stable(st.filt[PIN_A]);
	endproperty
	a_deglitch: assert property (p_deglitch)
		else $error("filter passed a short pulse");

	property p_sync_path;
		$changed(st.filt[PIN_B]) |-> st.filt[PIN_B] == $past(st.sync2[PIN_B]);
	endproperty
	a_sync_path: assert property (p_sync_path)
		else $error("filter bypassed the synchroniser");

	c_forward: cover property (bridge_out_a_hs_out && bridge_out_b_ls_out);
	c_ovp: cover property (ovp_brake && !awake);
	c_wake: cover property ($rose(awake) ##[1:40] bridge_out_a_hs_out);
	c_irq: cover property ($rose(irq_out));

endmodule : hbc_input_ctrl

// ### tb/hbc_host_model.sv
// host model driving the bridge inputs and the sleep line
`timescale 1ns/1ns
module hbc_host_model #(
	parameter int HOLD_CYC = 50
) (
	input wire logic clk_in,
	input wire logic fault_n_pin_in,
	output logic pin_input_a_out,
	output logic pin_input_b_out,
	output logic sleep_n_pin_out
);
	int cyc = 0;
	int last = 0;

	// ****************************************************************
	// cycle count, used to space input changes
	// ****************************************************************
	always @(posedge clk_in) cyc <= cyc + 1;

	initial begin
		pin_input_a_out = 1'b0;
		pin_input_b_out = 1'b0;
		sleep_n_pin_out = 1'b0;
	end

	// new levels, never faster than half a 200 khz period
	task automatic apply(input logic a, input logic b);
		while (cyc - last < HOLD_CYC) @(posedge clk_in);
		@(posedge clk_in);
		pin_input_a_out <= a;
		pin_input_b_out <= b;
		last = cyc;
	endtask : apply

	// one-cycle noise pulse on input a, on command only
	task automatic glitch_a();
		@(posedge clk_in);
		pin_input_a_out <= ~pin_input_a_out;
		@(posedge clk_in);
		pin_input_a_out <= ~pin_input_a_out;
	endtask : glitch_a

	// sleep line level, low puts the bridge to sleep
	task automatic set_sleep(input logic s);
		@(posedge clk_in);
		sleep_n_pin_out <= s;
	endtask : set_sleep
endmodule : hbc_host_model

// ### tb/hbc_input_ctrl_tb.sv
// self-checking bench for the bridge input control block
`timescale 1ns/1ns
module hbc_input_ctrl_tb import hbc_pkg::*;;
	localparam int DG = 2;
	localparam int DT = 2;
	localparam int SETTLE = DG + DT + 8;
	// {a_hs, a_ls, b_hs, b_ls}
	localparam logic [3:0] FWD = 4'h9;
	localparam logic [3:0] REV = 4'h6;
	localparam logic [3:0] BRK = 4'h5;
	localparam logic [3:0] CST = 4'h0;
	logic clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic pa, pb, sl, fault_oe, fault_pin, a_hs, a_ls, b_hs, b_ls, irq;
	logic overvoltage_brake = 1'b0;
	logic [2:0] flt = 3'h0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic fault_wire;
	logic [3:0] outs;
	int miscompares = 0;
	int n_checks = 0;

	// ****************************************************************
	// clock, wiring, instances
	// ****************************************************************
	always #25 clk_in = ~clk_in;
	// open-drain fault wire with its pull-up
	assign fault_wire = fault_oe ? fault_pin : 1'b1;
	assign outs = {a_hs, a_ls, b_hs, b_ls};

	hbc_host_model host (.clk_in(clk_in), .fault_n_pin_in(fault_wire),
		.pin_input_a_out(pa), .pin_input_b_out(pb), .sleep_n_pin_out(sl));

	hbc_input_ctrl #(.DEGLITCH_CYC_P(DG), .DEAD_CYC_P(DT)) dut (
		.clk_in(clk_in), .sys_rst_in(sys_rst_in),
		.pin_input_a_in(pa), .pin_input_b_in(pb), .sleep_n_pin_in(sl),
		.uvlo_in(flt[0]), .ocp_in(flt[1]), .tsd_in(flt[2]),
		.overvoltage_in(overvoltage_brake), .fault_n_pin_in(fault_wire),
		.fault_n_pin_out(fault_pin), .fault_n_pin_oe_out(fault_oe),
		.bridge_out_a_hs_out(a_hs), .bridge_out_a_ls_out(a_ls),
		.bridge_out_b_hs_out(b_hs), .bridge_out_b_ls_out(b_ls),
		.reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
		.reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
		.reg_rdata_out(reg_rdata), .irq_out(irq));

	// ****************************************************************
	// shared tasks
	// ****************************************************************
	task automatic chk(input string name, input logic [7:0] seen,
		input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_in);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_in);
		reg_wr <= 1'b0;
	endtask : wr

	// read data stand only in the cycle after the read edge
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk_in);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_in);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask : wait_cyc

	function automatic logic [3:0] exp_out(input logic s, a, b);
		if (!s) return a ? (b ? FWD : REV) : BRK;
		case ({a, b})
			2'b00: return CST;
			2'b01: return REV;
			2'b10: return FWD;
			default: return BRK;
		endcase
	endfunction : exp_out

	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_sim

	// ****************************************************************
	// scenarios
	// ****************************************************************
	// reset values, control mask, unmapped place
	task automatic t_reset();
		logic [7:0] d;
		chk("outs", {4'h0, outs}, 8'h00);
		chk("irq", {7'h0, irq}, 8'h00);
		rd(REG_CTRL, d);
		chk("ctrl", d, CTRL_RESET);
		rd(REG_INT_ENABLE, d);
		chk("int_en", d, {4'h0, INT_RESET});
		wr(REG_CTRL, 8'hff);
		rd(REG_CTRL, d);
		chk("ctrl_mask", d, CTRL_MASK);
		rd(4'hf, d);
		chk("unmapped", d, 8'h00);
	endtask : t_reset

	// every scheme and input pair, the unused source set opposite
	task automatic t_decode(input logic src);
		logic a, b;
		for (int s = 0; s < 2; s++) begin
			for (int i = 0; i < 4; i++) begin
				a = i[1];
				b = i[0];
				wr(REG_CTRL, {4'h0, src ? b : ~b, src ? a : ~a,
					s[0], src});
				host.apply(src ? ~a : a, src ? ~b : b);
				wait_cyc(SETTLE);
				chk("decode", {4'h0, outs}, {4'h0, exp_out(s[0], a, b)});
			end
		end
	endtask : t_decode

	// forward to reverse: each leg spends the dead gap high-z
	task automatic t_dead();
		int za = 0;
		int zb = 0;
		wr(REG_CTRL, 8'h00);
		host.apply(1'b1, 1'b1);
		wait_cyc(SETTLE);
		host.apply(1'b1, 1'b0);
		repeat (3 * SETTLE) begin
			wait_cyc(1);
			za += (outs[3:2] === 2'b00);
			zb += (outs[1:0] === 2'b00);
		end
		chk("dead_a", 8'(za), 8'(DT));
		chk("dead_b", 8'(zb), 8'(DT));
		chk("rev", {4'h0, outs}, {4'h0, REV});
	endtask : t_dead

	// a one-cycle pulse must not reach the legs
	task automatic t_glitch();
		int bad = 0;
		host.apply(1'b1, 1'b1);
		wait_cyc(SETTLE);
		host.glitch_a();
		repeat (SETTLE) begin
			wait_cyc(1);
			bad += (outs !== FWD);
		end
		chk("glitch", 8'(bad), 8'h00);
	endtask : t_glitch

	// sleep gives high-z, overvoltage while asleep brakes, irq path
	task automatic t_sleep_ovp();
		logic [7:0] d;
		host.set_sleep(1'b0);
		wait_cyc(SETTLE);
		chk("sleep", {4'h0, outs}, 8'h00);
		@(posedge clk_in);
		overvoltage_brake <= 1'b1;
		wait_cyc(SETTLE);
		chk("ovp_brake", {4'h0, outs}, {4'h0, BRK});
		rd(REG_INT_STATUS, d);
		chk("ovp_int", d, 8'h08);
		chk("irq_masked", {7'h0, irq}, 8'h00);
		wr(REG_INT_ENABLE, 8'h08);
		wait_cyc(2);
		chk("irq_on", {7'h0, irq}, 8'h01);
		wr(REG_INT_CLEAR, 8'h08);
		wait_cyc(2);
		chk("irq_off", {7'h0, irq}, 8'h00);
		@(posedge clk_in);
		overvoltage_brake <= 1'b0;
		host.set_sleep(1'b1);
		wait_cyc(SETTLE);
	endtask : t_sleep_ovp

	// each fault pulls the fault wire low and sets its status bit
	task automatic t_fault();
		logic [7:0] d;
		for (int i = 0; i < 3; i++) begin
			wr(REG_INT_ENABLE, 8'(1 << i));
			flt <= 3'(1 << i);
			wait_cyc(3);
			chk("fault_oe", {7'h0, fault_oe}, 8'h01);
			rd(REG_STATUS, d);
			chk("fault_wire", {7'h0, d[7]}, 8'h00);
			rd(REG_INT_STATUS, d);
			chk("fault_int", d, 8'(1 << i));
			chk("fault_irq", {7'h0, irq}, 8'h01);
			chk("fault_pin", {7'h0, fault_pin}, 8'h00);
			@(posedge clk_in);
			flt <= 3'h0;
			wr(REG_INT_CLEAR, 8'(1 << i));
			wait_cyc(3);
			chk("fault_rel", {6'h0, fault_oe, irq}, 8'h00);
		end
	endtask : t_fault

	// ****************************************************************
	// main sequence and watchdog
	// ****************************************************************
	initial begin
		repeat (12) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		@(posedge clk_in);
		#1;
		t_reset();
		host.set_sleep(1'b1);
		t_decode(1'b0);
		t_decode(1'b1);
		t_dead();
		t_glitch();
		t_sleep_ovp();
		t_fault();
		end_sim();
	end

	initial begin
		repeat (20000) @(posedge clk_in);
		miscompares++;
		end_sim();
	end
endmodule : hbc_input_ctrl_tb
